// ---- verilog/wbc_top.sv ----
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module wbc_top #(
   parameter int LANES = 2,
   parameter int BANK_W = 4,
   parameter int COL_W = 10,
   parameter int MAXD = 64,
   parameter logic [7:0] WR_CK = 8'h0c
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_axi_awvalid,
   output logic o_axi_awready,
   input wire logic [wbc_pkg::AXI_AW-1:0] i_axi_awaddr,
   input wire logic i_axi_wvalid,
   output logic o_axi_wready,
   input wire logic [31:0] i_axi_wdata,
   input wire logic [3:0] i_axi_wstrb,
   output logic o_axi_bvalid,
   input wire logic i_axi_bready,
   output logic [1:0] o_axi_bresp,
   input wire logic i_axi_arvalid,
   output logic o_axi_arready,
   input wire logic [wbc_pkg::AXI_AW-1:0] i_axi_araddr,
   output logic o_axi_rvalid,
   input wire logic i_axi_rready,
   output logic [31:0] o_axi_rdata,
   output logic [1:0] o_axi_rresp,
   input wire logic i_cmd_wr,
   input wire logic i_cmd_a10,
   input wire logic i_cmd_a12,
   input wire logic [BANK_W-1:0] i_cmd_bank,
   input wire logic [COL_W-1:0] i_cmd_col,
   input wire logic [2*LANES*8-1:0] i_dq,
   input wire logic [2*LANES-1:0] i_dm_n,
   output logic o_wr_done,
   output logic o_precharge,
   output logic [BANK_W-1:0] o_precharge_bank,
   output logic [(2**BANK_W)-1:0] o_bank_open,
   output logic o_crc_active,
   output logic o_crc_persistent
);
   import wbc_pkg::*;

   localparam int DQ_W = 2 * LANES * 8;
   localparam int BE_W = 2 * LANES;
   localparam int NBANK = 2 ** BANK_W;
   localparam int MA_W = BANK_W + COL_W - 1;
   localparam int SW = MA_W + BE_W + DQ_W;

   typedef struct packed {
      logic vld;
      logic bc4;
      logic ap;
      logic [BANK_W-1:0] bank;
      logic [COL_W-1:0] col;
   } wbc_desc_t;

   typedef struct packed {
      logic awrdy;
      logic aw_ok;
      logic [AXI_AW-1:0] awaddr;
      logic wrdy;
      logic w_ok;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arrdy;
      logic ar_pend;
      logic [AXI_AW-1:0] araddr;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] cfg;
      logic [15:0] maddr;
      logic [ERR_W-1:0] err;
      logic [15:0] wr_cnt;
      wbc_desc_t [MAXD-1:0] pipe;
      wbc_bst_t bst;
      logic [1:0] beat;
      wbc_desc_t cur;
      logic [3:0] gap;
      logic wr_done;
      logic ap_busy;
      logic [7:0] ap_cnt;
      logic [BANK_W-1:0] ap_bank;
      logic pre;
      logic [BANK_W-1:0] pre_bank;
      logic [NBANK-1:0] open;
      logic crc_on;
      logic crc_pers;
      logic last_bc4;
      logic sv;
      logic [SW-1:0] sd;
   } wbc_state_t;

   wbc_state_t st_reg;
   wbc_state_t st_next;

   wbc_stream_if #(.W(SW)) buf_in ();
   wbc_stream_if #(.W(SW)) buf_out ();
   logic rd_en;
   logic [DQ_W-1:0] mem_rdata;

   // byte-strobe merge for software writes
   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res;
   endfunction : strb_merge

   // next-state logic for the whole block
   always_comb begin
      logic [LAT_W:0] wl;
      logic [LAT_W:0] idx;
      logic [1:0] mode;
      logic cmd_bc4;
      logic pin_dm;
      logic capture;
      logic [1:0] bt;
      logic [1:0] last_bt;
      logic [1:0] lo;
      wbc_desc_t d;
      logic [ERR_W-1:0] err_set;
      logic [ERR_W-1:0] err_clr;
      logic [31:0] merged;
      wl = '0;
      idx = '0;
      mode = '0;
      cmd_bc4 = 1'b0;
      pin_dm = 1'b0;
      capture = 1'b0;
      bt = '0;
      last_bt = '0;
      lo = '0;
      d = '0;
      err_set = '0;
      err_clr = '0;
      merged = '0;
      rd_en = 1'b0;
      st_next = st_reg;

      // write address and data are taken in either order and held
      if (i_axi_awvalid && st_reg.awrdy) begin
         st_next.aw_ok = 1'b1;
         st_next.awaddr = i_axi_awaddr;
      end
      if (i_axi_wvalid && st_reg.wrdy) begin
         st_next.w_ok = 1'b1;
         st_next.wdata = i_axi_wdata;
         st_next.wstrb = i_axi_wstrb;
      end
      if (st_reg.bvalid && i_axi_bready) begin
         st_next.bvalid = 1'b0;
      end
      // register update once both halves are in
      if (st_reg.aw_ok && st_reg.w_ok && !st_reg.bvalid) begin
         st_next.aw_ok = 1'b0;
         st_next.w_ok = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = RESP_OKAY;
         merged = strb_merge(st_reg.cfg, st_reg.wdata, st_reg.wstrb);
         case (st_reg.awaddr)
            REG_CFG: begin
               st_next.cfg = merged & CFG_MASK;
            end
            REG_MADDR: begin
               merged = strb_merge({16'h0000, st_reg.maddr}, st_reg.wdata, st_reg.wstrb);
               st_next.maddr = merged[15:0];
            end
            REG_ERR: begin
               err_clr = st_reg.wdata[ERR_W-1:0] & {ERR_W{st_reg.wstrb[0]}};
            end
            default: begin
               st_next.bresp = RESP_SLVERR;
            end
         endcase
      end
      st_next.awrdy = !st_next.aw_ok && !st_next.bvalid;
      st_next.wrdy = !st_next.w_ok && !st_next.bvalid;

      // read: every answer comes one edge after the address is taken
      if (st_reg.rvalid && i_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      if (i_axi_arvalid && st_reg.arrdy) begin
         st_next.ar_pend = 1'b1;
         st_next.araddr = i_axi_araddr;
         rd_en = (i_axi_araddr == REG_MDATA);
      end
      if (st_reg.ar_pend) begin
         st_next.ar_pend = 1'b0;
         st_next.rvalid = 1'b1;
         st_next.rresp = RESP_OKAY;
         case (st_reg.araddr)
            REG_CFG: begin
               st_next.rdata = st_reg.cfg;
            end
            REG_STAT: begin
               st_next.rdata = '0;
               st_next.rdata[ST_OPEN_LSB +: 16] = 16'(st_reg.open);
               st_next.rdata[ST_BUSY] = (st_reg.bst == BS_DATA);
               st_next.rdata[ST_CRC] = st_reg.crc_on;
               st_next.rdata[ST_CRCP] = st_reg.crc_pers;
               st_next.rdata[ST_AP] = st_reg.ap_busy;
               st_next.rdata[ST_BC4] = st_reg.last_bc4;
            end
            REG_MADDR: begin
               st_next.rdata = {16'h0000, st_reg.maddr};
            end
            REG_MDATA: begin
               st_next.rdata = 32'(mem_rdata);
            end
            REG_ERR: begin
               st_next.rdata = 32'(st_reg.err);
            end
            REG_CNT: begin
               st_next.rdata = {16'h0000, st_reg.wr_cnt};
            end
            default: begin
               st_next.rdata = '0;
               st_next.rresp = RESP_SLVERR;
            end
         endcase
      end
      st_next.arrdy = !st_next.ar_pend && !st_next.rvalid;

      st_next.crc_on = st_reg.cfg[CFG_CRC];
      st_next.crc_pers = st_reg.cfg[CFG_CRC] && st_reg.cfg[CFG_DM];

      st_next.pre = 1'b0;
      if (st_reg.ap_busy) begin
         st_next.ap_cnt = st_reg.ap_cnt - 8'h01;
         if (st_reg.ap_cnt == 8'h01) begin
            st_next.ap_busy = 1'b0;
            st_next.pre = 1'b1;
            st_next.pre_bank = st_reg.ap_bank;
            st_next.open[st_reg.ap_bank] = 1'b0;
         end
      end

      // descriptors march one slot per clock toward slot zero
      st_next.pipe = {wbc_desc_t'(0), st_reg.pipe[MAXD-1:1]};
      st_next.gap = (st_reg.gap == GAP_MAX) ? GAP_MAX : st_reg.gap + GAP_ONE;
      mode = st_reg.cfg[CFG_BL_LSB +: 2];
      // write latency is AL plus CWL
      wl = (LAT_W + 1)'(st_reg.cfg[CFG_AL_LSB +: LAT_W]) + (LAT_W + 1)'(st_reg.cfg[CFG_CWL_LSB +: LAT_W]);
      idx = wl - (LAT_W + 1)'(1);
      cmd_bc4 = (mode == BL_FIXED4) || ((mode == BL_OTF) && !i_cmd_a12);
      if (i_cmd_wr) begin
         // each command carries its own length
         st_next.pipe[idx] = '{vld: 1'b1, bc4: cmd_bc4, ap: i_cmd_a10, bank: i_cmd_bank, col: i_cmd_col};
         st_next.open[i_cmd_bank] = 1'b1;
         st_next.wr_cnt = st_reg.wr_cnt + 16'h0001;
         st_next.gap = GAP_ONE;
         if (st_reg.cfg[CFG_PRE2] && (st_reg.cfg[CFG_CWL_LSB +: LAT_W] <= CWL_MIN)) begin
            err_set[ERR_CWL] = 1'b1;
         end
         if (st_reg.cfg[CFG_PRE2] && (st_reg.gap == GAP_FORBID)) begin
            err_set[ERR_GAP] = 1'b1;
         end
         if (st_reg.cfg[CFG_DM] && st_reg.cfg[CFG_DBI]) begin
            err_set[ERR_DMDBI] = 1'b1;
         end
      end

      // shared pin acts as mask only when neither inversion nor tdqs owns it
      pin_dm = st_reg.cfg[CFG_DM] && !st_reg.cfg[CFG_DBI] && !st_reg.cfg[CFG_TDQS];

      // burst engine: a fresh slot-zero descriptor always starts a burst
      unique case (st_reg.bst)
         BS_IDLE: begin
            capture = st_reg.pipe[0].vld;
         end
         BS_DATA: begin
            capture = 1'b1;
         end
      endcase
      d = st_reg.pipe[0].vld ? st_reg.pipe[0] : st_reg.cur;
      bt = st_reg.pipe[0].vld ? 2'h0 : st_reg.beat;
      st_next.wr_done = 1'b0;
      // a word left unaccepted by the buffer is lost, so flag it
      if (st_reg.sv && !buf_in.ready) begin
         err_set[ERR_OVF] = 1'b1;
      end
      st_next.sv = 1'b0;
      if (capture) begin
         // chop keeps two clocks, four beats
         last_bt = d.bc4 ? BC4_LAST : BL8_LAST;
         lo = d.bc4 ? {d.col[2], bt[0]} : bt;
         st_next.sv = 1'b1;
         st_next.sd = {d.bank, d.col[COL_W-1:3], lo, (pin_dm ? i_dm_n : {BE_W{1'b1}}), i_dq};
         st_next.cur = d;
         st_next.beat = bt + 2'h1;
         st_next.last_bc4 = d.bc4;
         if (bt == last_bt) begin
            st_next.bst = BS_IDLE;
            st_next.wr_done = 1'b1;
            if (d.ap) begin
               st_next.ap_busy = 1'b1;
               st_next.ap_cnt = WR_CK;
               st_next.ap_bank = d.bank;
            end
         end else begin
            st_next.bst = BS_DATA;
         end
      end

      // set wins over a clear in the same cycle
      st_next.err = (st_reg.err & ~err_clr) | err_set;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_reg <= '0;
         st_reg.awrdy <= 1'b1;
         st_reg.wrdy <= 1'b1;
         st_reg.arrdy <= 1'b1;
         st_reg.cfg <= CFG_RESET;
         st_reg.gap <= GAP_MAX;
         st_reg.bst <= BS_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // captured words pass the two-entry buffer on their way to the array
   assign buf_in.valid = st_reg.sv;
   assign buf_in.data = st_reg.sd;

   wbc_buf2 #(.W(SW)) u_buf (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .s_in(buf_in),
      .s_out(buf_out)
   );

   wbc_mem #(.AW(MA_W), .DW(DQ_W)) u_mem (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .s_wr(buf_out),
      .i_rd_en(rd_en),
      .i_rd_addr(st_reg.maddr[MA_W-1:0]),
      .o_rd_data(mem_rdata)
   );

   // outputs straight from state flops
   assign o_axi_awready = st_reg.awrdy;
   assign o_axi_wready = st_reg.wrdy;
   assign o_axi_bvalid = st_reg.bvalid;
   assign o_axi_bresp = st_reg.bresp;
   assign o_axi_arready = st_reg.arrdy;
   assign o_axi_rvalid = st_reg.rvalid;
   assign o_axi_rdata = st_reg.rdata;
   assign o_axi_rresp = st_reg.rresp;
   assign o_wr_done = st_reg.wr_done;
   assign o_precharge = st_reg.pre;
   assign o_precharge_bank = st_reg.pre_bank;
   assign o_bank_open = st_reg.open;
   assign o_crc_active = st_reg.crc_on;
   assign o_crc_persistent = st_reg.crc_pers;
endmodule : wbc_top

// ---- verilog/wbc_pkg.sv ----
package wbc_pkg;
   // register byte offsets
   localparam int AXI_AW = 8;
   localparam logic [AXI_AW-1:0] REG_CFG = 8'h00;
   localparam logic [AXI_AW-1:0] REG_STAT = 8'h04;
   localparam logic [AXI_AW-1:0] REG_MADDR = 8'h08;
   localparam logic [AXI_AW-1:0] REG_MDATA = 8'h0c;
   localparam logic [AXI_AW-1:0] REG_ERR = 8'h10;
   localparam logic [AXI_AW-1:0] REG_CNT = 8'h14;
   // config field layout
   localparam int CFG_BL_LSB = 0;
   localparam int CFG_PRE2 = 2;
   localparam int CFG_DM = 3;
   localparam int CFG_DBI = 4;
   localparam int CFG_TDQS = 5;
   localparam int CFG_CRC = 6;
   localparam int CFG_AL_LSB = 8;
   localparam int CFG_CWL_LSB = 16;
   localparam int LAT_W = 5;
   localparam logic [31:0] CFG_MASK = 32'h001f_1f7f;
   localparam logic [31:0] CFG_RESET = 32'h0009_0000;
   // burst field encodings
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_FIXED4 = 2'h2;
   // last clock index of a burst, two beats per clock
   localparam logic [1:0] BL8_LAST = 2'h3;
   localparam logic [1:0] BC4_LAST = 2'h1;
   // spacing and latency limits
   localparam logic [LAT_W-1:0] CWL_MIN = 5'h09;
   localparam logic [3:0] GAP_FORBID = 4'h5;
   localparam logic [3:0] GAP_ONE = 4'h1;
   localparam logic [3:0] GAP_MAX = 4'hf;
   // sticky error bits
   localparam int ERR_OVF = 0;
   localparam int ERR_CWL = 1;
   localparam int ERR_GAP = 2;
   localparam int ERR_DMDBI = 3;
   localparam int ERR_W = 4;
   // status bits
   localparam int ST_BUSY = 0;
   localparam int ST_CRC = 1;
   localparam int ST_CRCP = 2;
   localparam int ST_AP = 3;
   localparam int ST_BC4 = 4;
   localparam int ST_OPEN_LSB = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CLK_PERIOD_NS = 25;
   // burst engine states
   typedef enum logic [1:0] {
      BS_IDLE = 2'b01,
      BS_DATA = 2'b10
   } wbc_bst_t;
endpackage : wbc_pkg

// ---- verilog/wbc_stream_if.sv ----
`timescale 1ns/1ps
// valid/ready word stream between the burst engine, buffer and array
interface wbc_stream_if #(parameter int W = 8) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : wbc_stream_if

// ---- verilog/wbc_buf2.sv ----
`timescale 1ns/1ps
module wbc_buf2 #(
   parameter int W = 8
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   wbc_stream_if.snk s_in,
   wbc_stream_if.src s_out
);
   typedef struct packed {
      logic [W-1:0] d0;
      logic [W-1:0] d1;
      logic [1:0] cnt;
   } wbc_buf_t;
   wbc_buf_t st_reg;
   wbc_buf_t st_next;
   logic push;
   logic pop;

   // full at two entries, and ready ignores a pop in the same cycle, so a one-cycle drain stall mid-burst loses the next word
   assign s_in.ready = (st_reg.cnt != 2'h2);
   assign s_out.valid = (st_reg.cnt != 2'h0);
   assign s_out.data = st_reg.d0;
   assign push = s_in.valid && s_in.ready;
   assign pop = s_out.valid && s_out.ready;

   // entry d0 is always the head
   always_comb begin
      st_next = st_reg;
      if (pop && !push) begin
         st_next.d0 = st_reg.d1;
         st_next.cnt = st_reg.cnt - 2'h1;
      end else if (push && !pop) begin
         if (st_reg.cnt == 2'h0) begin
            st_next.d0 = s_in.data;
         end else begin
            st_next.d1 = s_in.data;
         end
         st_next.cnt = st_reg.cnt + 2'h1;
      end else if (push && pop) begin
         if (st_reg.cnt == 2'h1) begin
            st_next.d0 = s_in.data;
         end else begin
            st_next.d0 = st_reg.d1;
            st_next.d1 = s_in.data;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : wbc_buf2

// ---- verilog/wbc_mem.sv ----
`timescale 1ns/1ps
module wbc_mem #(
   parameter int AW = 13,
   parameter int DW = 32
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   wbc_stream_if.snk s_wr,
   input wire logic i_rd_en,
   input wire logic [AW-1:0] i_rd_addr,
   output logic [DW-1:0] o_rd_data
);
   localparam int BE = DW / 8;
   logic [DW-1:0] mem [0:(2**AW)-1];
   logic [AW-1:0] wa;
   logic [BE-1:0] wbe;
   logic [DW-1:0] wd;

   // single port: a software read takes the cycle and stalls the write side
   assign s_wr.ready = !i_rd_en;
   assign {wa, wbe, wd} = s_wr.data;

   // byte lanes with a clear enable keep their old contents
   always_ff @(posedge i_clk_sys) begin
      if (s_wr.valid && s_wr.ready) begin
         for (int b = 0; b < BE; b++) begin
            if (wbe[b]) begin
               mem[wa][b*8 +: 8] <= wd[b*8 +: 8];
            end
         end
      end
   end

   // registered read data
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rd_data <= '0;
      end else if (i_rd_en) begin
         o_rd_data <= mem[i_rd_addr];
      end
   end
endmodule : wbc_mem

// ---- verif/wbc_assertions.sv ----
`timescale 1ns/1ps
module wbc_assertions #(
   parameter int BANK_W = 4,
   parameter logic [7:0] WR_CK = 8'h0c
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_cmd_wr,
   input wire logic [BANK_W-1:0] i_cmd_bank,
   input wire logic o_wr_done,
   input wire logic o_precharge,
   input wire logic [BANK_W-1:0] o_precharge_bank,
   input wire logic [(2**BANK_W)-1:0] o_bank_open,
   input wire logic o_crc_active,
   input wire logic o_crc_persistent
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);
   // a command and the cycle after it, when the bank shows open
   sequence s_cmd;
      i_cmd_wr ##1 1'b1;
   endsequence
   property p_done_pulse;
      o_wr_done |=> !o_wr_done;
   endproperty
   property p_pre_pulse;
      o_precharge |=> !o_precharge;
   endproperty
   property p_pre_gap;
      o_precharge |-> $past(o_wr_done, WR_CK);
   endproperty
   property p_pre_close;
      o_precharge |-> !o_bank_open[o_precharge_bank];
   endproperty
   property p_open;
      s_cmd |-> o_bank_open[$past(i_cmd_bank)];
   endproperty
   property p_open_cause;
      |(o_bank_open & ~$past(o_bank_open)) |-> $past(i_cmd_wr);
   endproperty
   property p_close_cause;
      |(~o_bank_open & $past(o_bank_open)) |-> o_precharge;
   endproperty
   property p_crc;
      o_crc_persistent |-> o_crc_active;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
   a_pre_pulse: assert property (p_pre_pulse) else $error("precharge longer than one cycle");
   a_pre_gap: assert property (p_pre_gap) else $error("precharge not at recovery end");
   a_pre_close: assert property (p_pre_close) else $error("bank open at precharge");
   a_open: assert property (p_open) else $error("bank not open after write");
   a_open_cause: assert property (p_open_cause) else $error("bank opened without command");
   a_close_cause: assert property (p_close_cause) else $error("bank closed without precharge");
   a_crc: assert property (p_crc) else $error("persistent crc without crc");
endmodule : wbc_assertions
bind wbc_top wbc_assertions #(.BANK_W(BANK_W), .WR_CK(WR_CK)) u_chk (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
   .i_cmd_wr(i_cmd_wr), .i_cmd_bank(i_cmd_bank), .o_wr_done(o_wr_done), .o_precharge(o_precharge),
   .o_precharge_bank(o_precharge_bank), .o_bank_open(o_bank_open), .o_crc_active(o_crc_active),
   .o_crc_persistent(o_crc_persistent));

// ---- verif/wbc_ctrl_model.sv ----
`timescale 1ns/1ps
module wbc_ctrl_model (
   input wire logic i_clk_sys,
   input wire logic i_go,
   input wire logic i_a10,
   input wire logic i_a12,
   input wire logic [3:0] i_bank,
   input wire logic [9:0] i_col,
   input wire logic [31:0] i_base,
   input wire logic [15:0] i_dm_n,
   input wire logic [5:0] i_wl,
   output logic o_cmd_wr,
   output logic o_a10,
   output logic o_a12,
   output logic [3:0] o_bank,
   output logic [9:0] o_col,
   output logic [31:0] o_dq,
   output logic [3:0] o_dm_n
);
   logic [31:0] dq_s [64];
   logic [3:0] dm_s [64];
   bit v_s [64];
   int t = 0;
   int k;
   int j;
   initial begin
      {o_cmd_wr, o_a10, o_a12, o_bank, o_col, o_dq, o_dm_n} = '0;
   end
   // slots hold each data clock until the write latency has run out
   always @(posedge i_clk_sys) begin
      k = t % 64;
      if (v_s[k]) begin
         o_dq <= dq_s[k];
         o_dm_n <= dm_s[k];
         v_s[k] = 1'b0;
      end else begin
         // idle bus toggles so a stale beat never looks valid
         o_dq <= ~o_dq;
         o_dm_n <= ~o_dm_n;
      end
      o_cmd_wr <= i_go;
      o_a12 <= i_go ? i_a12 : ~o_a12;
      o_a10 <= i_go ? i_a10 : ~o_a10;
      o_bank <= i_go ? i_bank : ~o_bank;
      o_col <= i_go ? i_col : ~o_col;
      // whole window driven, chop tail left to the device
      if (i_go) begin
         for (j = 0; j < 4; j++) begin
            dq_s[(t + i_wl + j) % 64] = i_base + {4{8'(j)}};
            dm_s[(t + i_wl + j) % 64] = i_dm_n[4*j +: 4];
            v_s[(t + i_wl + j) % 64] = 1'b1;
         end
      end
      t = t + 1;
   end
endmodule : wbc_ctrl_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %0t %s", $time, m); end end
module tb_top;
   import wbc_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic [7:0] awa = 8'h0, ara = 8'h0;
   logic [31:0] wd = 32'h0, base = 32'h0, rd;
   logic go = 1'b0, a10 = 1'b0, a12 = 1'b0, awr, wrd, bv, arr, rv, done, pre;
   logic c_wr, c_a10, c_a12, crc, crcp;
   logic [3:0] bk = 4'h0, c_bank, dmn, pbank;
   logic [9:0] col = 10'h0, c_col;
   logic [15:0] dm = 16'h0, bopen;
   logic [5:0] wl = 6'h4;
   logic [31:0] dq;
   logic [1:0] bresp, rresp, r;
   logic [31:0] em [int];
   int mismatches = 0, comparisons = 0;
   wbc_top #(.WR_CK(8'h02)) dut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_axi_awvalid(awv), .o_axi_awready(awr),
      .i_axi_awaddr(awa), .i_axi_wvalid(wv), .o_axi_wready(wrd), .i_axi_wdata(wd), .i_axi_wstrb(4'hf),
      .o_axi_bvalid(bv), .i_axi_bready(br), .o_axi_bresp(bresp), .i_axi_arvalid(arv), .o_axi_arready(arr),
      .i_axi_araddr(ara), .o_axi_rvalid(rv), .i_axi_rready(rr), .o_axi_rdata(rd), .o_axi_rresp(rresp),
      .i_cmd_wr(c_wr), .i_cmd_a10(c_a10), .i_cmd_a12(c_a12), .i_cmd_bank(c_bank), .i_cmd_col(c_col), .i_dq(dq),
      .i_dm_n(dmn), .o_wr_done(done), .o_precharge(pre), .o_precharge_bank(pbank), .o_bank_open(bopen),
      .o_crc_active(crc), .o_crc_persistent(crcp));
   wbc_ctrl_model u_ctrl (.i_clk_sys(clk), .i_go(go), .i_a10(a10), .i_a12(a12), .i_bank(bk), .i_col(col),
      .i_base(base), .i_dm_n(dm), .i_wl(wl), .o_cmd_wr(c_wr), .o_a10(c_a10), .o_a12(c_a12), .o_bank(c_bank),
      .o_col(c_col), .o_dq(dq), .o_dm_n(dmn));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic conclude;
      if (mismatches == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   // register word from burst mode, flags {crc,tdqs,dbi,dm,pre2}, additive and write latency
   function automatic logic [31:0] cfg(input logic [1:0] bl, input logic [4:0] fl, input logic [4:0] al,
      input logic [4:0] cwl);
      cfg = {11'h0, cwl, 3'h0, al, 1'b0, fl, bl};
   endfunction : cfg
   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
      @(posedge clk);
      awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= v; br <= 1'b1;
      fork
         begin do @(posedge clk); while (awr !== 1'b1); awv <= 1'b0; end
         begin do @(posedge clk); while (wrd !== 1'b1); wv <= 1'b0; end
      join
      do @(posedge clk); while (bv !== 1'b1);
      br <= 1'b0;
      rsp = bresp;
   endtask : axw
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      arv <= 1'b1; ara <= a; rr <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rv !== 1'b1);
      rr <= 1'b0;
      `CHK(rd, e, "read data")
      `CHK(rresp, er, "read response")
   endtask : rchk
   // expected array is updated before the command so overlapping bursts stay simple
   task automatic issue(input logic x10, input logic x12, input logic ch, input logic [3:0] b, input logic [9:0] c,
      input logic [31:0] v, input logic [15:0] m, input logic mon);
      logic [12:0] ad;
      logic [31:0] w;
      for (int j = 0; j < (ch ? 2 : 4); j++) begin
         ad = {b, c[9:3], ch ? {c[2], j[0]} : 2'(j)};
         w = v + {4{8'(j)}};
         for (int l = 0; l < 4; l++)
            if (!mon || m[4*j+l]) em[ad][8*l +: 8] = w[8*l +: 8];
      end
      @(posedge clk);
      go <= 1'b1; a10 <= x10; a12 <= x12; bk <= b; col <= c; base <= v; dm <= m;
      @(posedge clk);
      go <= 1'b0;
   endtask : issue
   task automatic wait_done(input int e);
      int n;
      n = 1;
      while (done !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      `CHK(n, e, "done timing")
   endtask : wait_done
   task automatic chkmem(input logic [3:0] b, input logic [9:0] c);
      logic [12:0] ad;
      for (int k = 0; k < 4; k++) begin
         ad = {b, c[9:3], 2'(k)};
         if (em.exists(ad)) begin
            axw(REG_MADDR, {19'h0, ad}, r);
            rchk(REG_MDATA, em[ad], RESP_OKAY);
         end
      end
   endtask : chkmem
   initial begin
      static logic [1:0] md [4] = '{BL_FIXED8, BL_OTF, BL_OTF, BL_FIXED4};
      static logic a12t [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
      static logic cht [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rchk(REG_CFG, CFG_RESET, RESP_OKAY);
      rchk(8'h18, 32'h0, RESP_SLVERR);
      axw(REG_CNT, 32'h5, r);
      `CHK(r, RESP_SLVERR, "read-only write")
      // every burst mode, with the additive part of the latency stepped
      for (int i = 0; i < 4; i++) begin
         axw(REG_CFG, cfg(md[i], 5'h0, 5'(i), 5'h04), r);
         wl <= 6'(i + 4);
         issue(1'b0, a12t[i], cht[i], 4'(i), 10'h008, 32'h10203040 * (i + 1), 16'hffff, 1'b0);
         wait_done(i + 4 + (cht[i] ? 4 : 6));
         `CHK(bopen[i], 1'b1, "bank open")
         chkmem(4'(i), 10'h008);
      end
      // mixed lengths back to back, masked chop into a full burst, then auto precharge
      axw(REG_CFG, cfg(BL_OTF, 5'h02, 5'h0, 5'h04), r);
      wl <= 6'h4;
      issue(1'b0, 1'b1, 1'b0, 4'h6, 10'h010, 32'ha0b0c0d0, 16'hffff, 1'b1);
      repeat (2) @(posedge clk);
      issue(1'b0, 1'b0, 1'b1, 4'h6, 10'h014, 32'h55667788, 16'h00a5, 1'b1);
      repeat (2) @(posedge clk);
      issue(1'b1, 1'b1, 1'b0, 4'h7, 10'h020, 32'h01234567, 16'h3cc3, 1'b1);
      repeat (20) @(posedge clk);
      `CHK(bopen[7:6], 2'b01, "bank states")
      `CHK(pbank, 4'h7, "precharge bank")
      // banks 0-3 and 6 open, 7 closed, nothing pending, last burst full
      rchk(REG_STAT, 32'h004f_0000, RESP_OKAY);
      chkmem(4'h6, 10'h010);
      chkmem(4'h7, 10'h020);
      // the pin serving as strobe termination leaves no mask
      axw(REG_CFG, cfg(BL_OTF, 5'h0a, 5'h0, 5'h04), r);
      issue(1'b0, 1'b1, 1'b0, 4'h8, 10'h030, 32'h99aabbcc, 16'h0000, 1'b0);
      repeat (12) @(posedge clk);
      chkmem(4'h8, 10'h030);
      // mask setting picks the crc flavour
      for (int i = 0; i < 2; i++) begin
         axw(REG_CFG, cfg(BL_OTF, {4'h8, 1'b0} | {3'h0, 1'(i), 1'b0}, 5'h0, 5'h04), r);
         repeat (2) @(posedge clk);
         `CHK({crc, crcp}, {1'b1, 1'(i)}, "crc mode")
      end
      // two-clock preamble with lowest latency and five-clock spacing gets flagged
      axw(REG_ERR, 32'hf, r);
      axw(REG_CFG, cfg(BL_OTF, 5'h01, 5'h0, 5'h09), r);
      wl <= 6'h9;
      issue(1'b0, 1'b1, 1'b0, 4'h9, 10'h040, 32'h0, 16'hffff, 1'b0);
      repeat (3) @(posedge clk);
      issue(1'b0, 1'b1, 1'b0, 4'h9, 10'h048, 32'h0, 16'hffff, 1'b0);
      repeat (20) @(posedge clk);
      rchk(REG_ERR, 32'h6, RESP_OKAY);
      rchk(REG_CNT, 32'd10, RESP_OKAY);
      conclude();
   end
   // cut a hang short well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end
endmodule : tb_top
